// ===== packet_status_flags.sv
module packet_status_flags
	import packet_status_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	output logic            irq,
	input  wire logic       tx_mode,
	input  wire logic       tx_packet_done,
	input  wire logic       rx_mode,
	input  wire logic       rx_last_byte,
	input  wire logic       rx_checksum_pass,
	input  wire logic       queue_empty,
	input  wire logic       queue_overrun,
	input  wire logic       battery_low_async,
	output logic            queue_flush,
	output logic            packet_done_flag,
	output logic            rx_payload_available,
	output logic            checksum_good_flag,
	output logic            supply_low_flag
);

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic       pd_reg, pd_next;
	logic       pa_reg, pa_next;
	logic       ck_reg, ck_next;
	logic       sl_reg, sl_next;
	logic       ov_reg, ov_next;
	logic [1:0] ctrl_reg;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_stat_next;
	logic [3:0] irq_mask_reg;
	logic [7:0] rdata_reg;
	logic       flush_reg;
	logic       irq_reg;
	logic       bat_meta_reg, bat_sync_reg;
	logic [3:0] flags_prev_reg;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	wire        wr_status   = wr_en && (addr == STATUS_ADDR);
	wire        wr_irq_stat = wr_en && (addr == IRQ_STATUS_ADDR);
	wire        wr_irq_mask = wr_en && (addr == IRQ_MASK_ADDR);
	wire        wr_control  = wr_en && (addr == CONTROL_ADDR);
	// Only bits 0 and 4 of the status byte accept writes; the rest are read-only
	wire        clear_low   = wr_status && wdata[SUPPLY_LOW_BIT];
	wire        clear_ovr   = wr_status && wdata[OVERRUN_BIT];
	wire        chk_enable  = ctrl_reg[CHECKSUM_EN_BIT];
	wire        keep_bad    = ctrl_reg[KEEP_BAD_BIT];
	wire        chk_gate    = !chk_enable || keep_bad || rx_checksum_pass;
	wire        payload_set = rx_mode && rx_last_byte && chk_gate;
	wire        chk_set     = rx_mode && rx_last_byte && rx_checksum_pass;
	wire        pd_set      = tx_mode && tx_packet_done;
	wire        sl_set      = bat_sync_reg;
	wire [3:0]  flags_now   = {pd_reg, pa_reg, ck_reg, sl_reg};
	wire [3:0]  flag_rise   = flags_now & ~flags_prev_reg;

	wire [7:0]  status_byte = {3'h0, ov_reg, pd_reg, pa_reg, ck_reg, sl_reg};
	wire [7:0]  rd_mux      = (addr == STATUS_ADDR)     ? status_byte :
	                          (addr == IRQ_STATUS_ADDR) ? {4'h0, irq_stat_reg} :
	                          (addr == IRQ_MASK_ADDR)   ? {4'h0, irq_mask_reg} :
	                          (addr == CONTROL_ADDR)    ? {6'h00, ctrl_reg} :
	                          ZERO_BYTE;

	////////////////////////////////////////////////////////////////////////////
	// Flag next-state

	always_comb begin
		// Leaving transmit wins; a completion outside transmit cannot set it
		pd_next = (pd_reg || pd_set) && tx_mode;
		// Emptied queue clears; overrun acknowledge also clears. Set wins the tie.
		pa_next = payload_set || (pa_reg && !queue_empty && !clear_ovr);
		ck_next = chk_set || (ck_reg && !queue_empty && !clear_ovr);
		// Battery flag ignores every clear but its own acknowledge; set wins
		sl_next = sl_set || (sl_reg && !clear_low);
		ov_next = queue_overrun || (ov_reg && !clear_ovr);
		if (clear_ovr) begin
			pd_next = pd_set && tx_mode;
		end
		irq_stat_next = flag_rise | (irq_stat_reg & ~(wr_irq_stat ? wdata[3:0] : 4'h0));
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequential

	always_ff @(posedge clock) begin
		// The battery comparator is analog and asynchronous to this clock
		bat_meta_reg <= battery_low_async;
		bat_sync_reg <= bat_meta_reg;
		if (!rst_n) begin
			pd_reg         <= 1'b0;
			pa_reg         <= 1'b0;
			ck_reg         <= 1'b0;
			sl_reg         <= 1'b0;
			ov_reg         <= 1'b0;
			ctrl_reg       <= CONTROL_RESET;
			irq_stat_reg   <= IRQ_RESET;
			irq_mask_reg   <= IRQ_RESET;
			rdata_reg      <= ZERO_BYTE;
			flush_reg      <= 1'b0;
			irq_reg        <= 1'b0;
			flags_prev_reg <= IRQ_RESET;
		end else begin
			pd_reg         <= pd_next;
			pa_reg         <= pa_next;
			ck_reg         <= ck_next;
			sl_reg         <= sl_next;
			ov_reg         <= ov_next;
			flags_prev_reg <= flags_now;
			irq_stat_reg   <= irq_stat_next;
			irq_reg        <= |(irq_stat_next & irq_mask_reg);
			flush_reg      <= clear_ovr;
			rdata_reg      <= rd_en ? rd_mux : ZERO_BYTE;
			if (wr_irq_mask) begin
				irq_mask_reg <= wdata[3:0];
			end
			if (wr_control) begin
				ctrl_reg <= wdata[1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign rdata                = rdata_reg;
	assign irq                  = irq_reg;
	assign queue_flush          = flush_reg;
	assign packet_done_flag     = pd_reg;
	assign rx_payload_available = pa_reg;
	assign checksum_good_flag   = ck_reg;
	assign supply_low_flag      = sl_reg;

endmodule : packet_status_flags

// ===== packet_status_flags_props.sv
module packet_status_flags_props
	import packet_status_pkg::*;
(
	input wire logic       clock, rst_n, wr_en, tx_mode, tx_packet_done, rx_mode, rx_last_byte,
	input wire logic       rx_checksum_pass, queue_empty, battery_low_async, queue_flush,
	input wire logic       packet_done_flag, rx_payload_available, checksum_good_flag,
	input wire logic       supply_low_flag,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire sw  = wr_en && addr == STATUS_ADDR;
	wire fin = rx_mode && rx_last_byte;
	// Set wins over a clear in the same cycle, so clears are checked without a set
	property p_done; tx_mode && tx_packet_done |=> packet_done_flag; endproperty
	a_done: assert property (p_done) else $error("done not set");
	property p_avl; fin && rx_checksum_pass |=> rx_payload_available; endproperty
	a_avl: assert property (p_avl) else $error("payload not set");
	property p_avl_clr; queue_empty && !fin |=> !rx_payload_available; endproperty
	a_avl_clr: assert property (p_avl_clr) else $error("payload not cleared");
	property p_chk_clr; queue_empty && !fin |=> !checksum_good_flag; endproperty
	a_chk_clr: assert property (p_chk_clr) else $error("checksum not cleared");
	property p_low; battery_low_async [*3] |=> supply_low_flag; endproperty
	a_low: assert property (p_low) else $error("supply not set");
	property p_stk; supply_low_flag && !(sw && wdata[0]) |=> $stable(supply_low_flag); endproperty
	a_stk: assert property (p_stk) else $error("supply dropped");
	property p_fl; sw && wdata[4] && !fin |=> queue_flush && !checksum_good_flag; endproperty
	a_fl: assert property (p_fl) else $error("no flush");
	property p_ro; sw && !wdata[4] && tx_mode && packet_done_flag |=> packet_done_flag; endproperty
	a_ro: assert property (p_ro) else $error("done written");
endmodule : packet_status_flags_props

// ===== packet_status_flags_tb.sv
module packet_status_flags_tb import packet_status_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst_n = 0, wr_en = 0, rd_en = 0, tx_mode = 0, tx_packet_done = 0, rv = 0;
	logic rx_mode = 0, rx_last_byte = 0, rx_checksum_pass = 0, queue_empty = 1, queue_overrun = 0;
	logic battery_low_async = 0, irq, queue_flush, packet_done_flag, rx_payload_available;
	logic checksum_good_flag, supply_low_flag;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, e, ist = 8'h09, q[$];
	logic [15:0] seed = 16'h79fe;
	int err_count = 0, total_checks = 0, cyc = 0;
	packet_status_flags packet_status_flags_inst (.*);
	initial forever #5 clock = ~clock;
	////////////////////////////////////////////////////////////////////////
	function void xs();
		seed ^= seed << 7;
		seed ^= seed >> 9;
		seed ^= seed << 8;
	endfunction : xs
	task chk(logic [7:0] g, logic [7:0] x);
		total_checks++;
		if (g !== x) begin
			$display("wrong value %0t got %h exp %h", $time, g, x);
			err_count++;
		end
	endtask : chk
	// A read carries its expected byte on wdata, which the slave ignores
	task bus(logic w, logic [3:0] a, logic [7:0] d);
		@(posedge clock);
		{wr_en, rd_en, addr, wdata} <= {w, !w, a, d};
		if (!w) q.push_back(d);
		@(posedge clock);
		{wr_en, rd_en} <= 2'b00;
	endtask : bus
	task close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	always @(posedge clock) begin
		rv <= rd_en;
		if (rv) chk(rdata, q.pop_front());
		if (++cyc > 3000) begin
			err_count++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1;
		bus(0, STATUS_ADDR, 8'h00);
		bus(0, 4'h9, 8'h00);
		tx_mode <= 1;
		tx_packet_done <= 1;
		@(posedge clock);
		tx_packet_done <= 0;
		bus(0, STATUS_ADDR, 8'h08);
		@(negedge clock) chk({4'h0, packet_done_flag, rx_payload_available,
			checksum_good_flag, supply_low_flag}, 8'h08);
		bus(1, STATUS_ADDR, 8'h0e);
		bus(0, STATUS_ADDR, 8'h08);
		tx_mode <= 0;
		bus(0, STATUS_ADDR, 8'h00);
		{queue_empty, rx_mode} <= 2'b01;
		for (int i = 0; i < 4; i++) begin
			xs();
			bus(1, CONTROL_ADDR, 8'(i));
			{rx_last_byte, rx_checksum_pass} <= {1'b1, seed[0]};
			@(posedge clock);
			rx_last_byte <= 0;
			e = {5'h0, !i[0] || i[1] || seed[0], seed[0], 1'b0};
			ist |= e;
			bus(0, STATUS_ADDR, e);
			queue_empty <= 1;
			bus(0, STATUS_ADDR, 8'h00);
			queue_empty <= 0;
		end
		battery_low_async <= 1;
		repeat (4) @(posedge clock);
		battery_low_async <= 0;
		bus(0, STATUS_ADDR, 8'h01);
		@(negedge clock) chk({4'h0, packet_done_flag, rx_payload_available,
			checksum_good_flag, supply_low_flag}, 8'h01);
		bus(1, STATUS_ADDR, 8'h00);
		bus(0, STATUS_ADDR, 8'h01);
		bus(1, STATUS_ADDR, 8'h01);
		bus(0, STATUS_ADDR, 8'h00);
		bus(0, IRQ_STATUS_ADDR, ist);
		@(negedge clock) chk(irq, 0);
		bus(1, IRQ_MASK_ADDR, 8'h0f);
		@(posedge clock);
		@(negedge clock) chk(irq, 1);
		bus(1, IRQ_STATUS_ADDR, 8'h0f);
		@(negedge clock) chk(irq, 0);
		@(posedge clock);
		{rx_last_byte, rx_checksum_pass, queue_overrun} <= 3'b111;
		@(posedge clock);
		{rx_last_byte, queue_overrun} <= 2'b00;
		bus(0, STATUS_ADDR, 8'h16);
		bus(1, STATUS_ADDR, 8'h10);
		#1 chk(queue_flush, 1);
		bus(0, STATUS_ADDR, 8'h00);
		close_out();
	end
endmodule : packet_status_flags_tb
bind packet_status_flags packet_status_flags_props packet_status_flags_props_inst (.*);

// ===== packet_status_pkg.sv
package packet_status_pkg;

	// Register offsets on the plain register port
	localparam logic [3:0] STATUS_ADDR     = 4'h0;
	localparam logic [3:0] IRQ_STATUS_ADDR = 4'h1;
	localparam logic [3:0] IRQ_MASK_ADDR   = 4'h2;
	localparam logic [3:0] CONTROL_ADDR    = 4'h3;

	// Flag positions within the status byte
	localparam int SUPPLY_LOW_BIT   = 0;
	localparam int CHECKSUM_OK_BIT  = 1;
	localparam int PAYLOAD_AVL_BIT  = 2;
	localparam int PACKET_DONE_BIT  = 3;
	localparam int OVERRUN_BIT      = 4;

	// Control register fields
	localparam int CHECKSUM_EN_BIT  = 0;
	localparam int KEEP_BAD_BIT     = 1;

	localparam logic [7:0] ZERO_BYTE     = 8'h00;
	localparam logic [3:0] IRQ_RESET     = 4'h0;
	localparam logic [1:0] CONTROL_RESET = 2'h0;

endpackage : packet_status_pkg
